// *** hw/pucd_pkg.sv ***
// Notes on behaviour
// [RULE1] above power-on level, programmable outputs asserted low
// [RULE2] above lockout level, start nonvolatile-to-latch copy
// [RULE3] copy finishes within 2.5 ms
// [RULE4] after lockout, outputs follow programmed conditions
// [RULE5] serial traffic before copy done is NACKed
// [RULE6] register writes act within 5 us
// [RULE7] threshold changes act after 150 us
// [RULE8] nonvolatile writes need reboot to take effect
// [RULE9] nonvolatile image spans pointers 80h to 9Fh
// [RULE10] volatile latches span pointers 00h to 2Fh; host writes are taken only below 2Fh
// [RULE11] copy location to same position, then done
package pucd_pkg;
  localparam int unsigned CLK_HZ         = 20_000_000;
  localparam int unsigned LOAD_MAX_NS    = 2_500_000;  // 2.5 ms copy limit
  localparam int unsigned REG_LAT_NS     = 5_000;      // 5 us register latency
  localparam int unsigned THR_LAT_NS     = 150_000;    // 150 us threshold settling
  localparam int unsigned LOAD_MAX_CYC   = LOAD_MAX_NS / 50;  // rounded down
  localparam int unsigned REG_LAT_CYC    = REG_LAT_NS / 50;
  localparam int unsigned THR_LAT_CYC    = THR_LAT_NS / 50;
  localparam logic [7:0]  NV_FIRST       = 8'h80;
  localparam logic [7:0]  NV_LAST        = 8'h9f;
  localparam logic [7:0]  VOL_FIRST      = 8'h00;
  localparam logic [7:0]  VOL_LAST       = 8'h2f;
  localparam logic [7:0]  CFG_RESET_VAL  = 8'h00;
  typedef enum logic [1:0] {ST_OFF, ST_HOLD, ST_LOAD, ST_RUN} pucd_state_t;
endpackage : pucd_pkg

// *** hw/pucd_loader.sv ***
module pucd_loader #(
  parameter int unsigned REG_LAT = pucd_pkg::REG_LAT_CYC, // register write latency
  parameter int unsigned THR_LAT = pucd_pkg::THR_LAT_CYC, // threshold settling
  parameter int unsigned OUT_N   = 3                       // programmable outputs
) (
  input  wire logic             clk_i,         // 20 MHz clock
  input  wire logic             resetn_i,      // async reset, active low
  input  wire logic             por_level_i,   // supply above power-on level (async)
  input  wire logic             lockout_ok_i,  // above supply_lockout_level (async)
  input  wire logic             reboot_i,      // software reboot pulse
  input  wire logic [7:0]       nv_rdata_i,    // nonvolatile data, one cycle after addr
  output logic      [7:0]       nv_addr_o,     // nonvolatile read pointer
  input  wire logic             wr_i,          // host write to volatile register
  input  wire logic [7:0]       wr_addr_i,     // host write pointer
  input  wire logic [7:0]       wr_data_i,     // host write data
  input  wire logic             wr_thr_i,      // write is a detector threshold
  input  wire logic [7:0]       cfg_addr_i,    // active configuration read pointer
  output logic      [7:0]       cfg_data_o,    // active configuration value
  output logic                  cfg_busy_o,    // a write still pending
  input  wire logic             host_req_i,    // host addresses the device
  output logic                  host_nack_o,   // answer NACK to host
  output logic                  done_o,        // configuration loaded
  input  wire logic [OUT_N-1:0] out_cond_i,    // programmed output conditions
  output logic      [OUT_N-1:0] outs_n_o       // programmable outputs, low active
);
  localparam int unsigned DEPTH = 48;
  // two-flop synchronisers on the analog comparator levels
  logic [1:0] por_s_ff, lk_s_ff;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      por_s_ff <= 2'b00;
      lk_s_ff  <= 2'b00;
    end else begin
      por_s_ff <= {por_s_ff[0], por_level_i};
      lk_s_ff  <= {lk_s_ff[0], lockout_ok_i};
    end
  end
  wire por_ok = por_s_ff[1];
  wire lk_ok  = lk_s_ff[1];

  ////////////////////////////////////////////////////////////////////////
  // load sequencer
  // the pointer register and the memory's own output register put two
  // cycles between issuing an entry and seeing its data, so the entry
  // index and its valid bit travel down a matching two-stage pipe;
  // a single stage would land every byte one latch too high
  pucd_pkg::pucd_state_t st_ff, nxt_st;
  logic [5:0] idx_ff;    // entry whose pointer is being issued
  logic [5:0] wi1_ff;    // entry whose pointer stands on nv_addr_o
  logic       v1_ff;     // wi1_ff is a live entry
  logic       rd_v_ff;   // nv data for wi_ff is valid this cycle
  logic [5:0] wi_ff;     // entry whose data stands on nv_rdata_i
  wire        last_rd  = (idx_ff == 6'(DEPTH - 1));
  wire        load_end = rd_v_ff && (wi_ff == 6'(DEPTH - 1));
  // [RULE2] copy starts at lockout
  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      pucd_pkg::ST_OFF:  if (por_ok) nxt_st = pucd_pkg::ST_HOLD;
      pucd_pkg::ST_HOLD: if (lk_ok) nxt_st = pucd_pkg::ST_LOAD;
      pucd_pkg::ST_LOAD: if (load_end) nxt_st = pucd_pkg::ST_RUN;
      pucd_pkg::ST_RUN:  if (reboot_i) nxt_st = pucd_pkg::ST_LOAD;
      default:           nxt_st = pucd_pkg::ST_OFF;
    endcase
    if (!por_ok) nxt_st = pucd_pkg::ST_OFF;
    else if (!lk_ok && st_ff != pucd_pkg::ST_OFF) nxt_st = pucd_pkg::ST_HOLD;
  end
  wire loading = (st_ff == pucd_pkg::ST_LOAD);
  wire start   = (nxt_st == pucd_pkg::ST_LOAD) && !loading;

  // [RULE9] nonvolatile pointer walks 80h..9Fh
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_ff   <= pucd_pkg::ST_OFF;
      idx_ff  <= 6'h00;
      wi1_ff  <= 6'h00;
      v1_ff   <= 1'b0;
      rd_v_ff <= 1'b0;
      wi_ff   <= 6'h00;
    end else begin
      st_ff   <= nxt_st;
      // issue stops on the edge that leaves the load; the one entry still
      // in flight rewrites the last latch with the same value, harmlessly
      v1_ff   <= loading && (nxt_st == pucd_pkg::ST_LOAD);
      rd_v_ff <= v1_ff;
      wi1_ff  <= idx_ff;
      wi_ff   <= wi1_ff;
      if (start) idx_ff <= 6'h00;
      else if (loading && !last_rd) idx_ff <= idx_ff + 6'h01;
    end
  end
  // the image is only 32 bytes; latches above it clear to reset value
  wire [7:0] nv_ptr = pucd_pkg::NV_FIRST + {2'b00, idx_ff};
  wire       nv_in  = (nv_ptr <= pucd_pkg::NV_LAST);
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) nv_addr_o <= pucd_pkg::NV_FIRST;
    else nv_addr_o <= nv_in ? nv_ptr : pucd_pkg::NV_LAST;
  end
  // image-range flag follows its entry down the same two stages
  logic nv_in1_ff;
  logic nv_in_d_ff;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      nv_in1_ff  <= 1'b0;
      nv_in_d_ff <= 1'b0;
    end else begin
      nv_in1_ff  <= nv_in;
      nv_in_d_ff <= nv_in1_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // volatile latches and delayed host writes
  logic [7:0]  vol_ff [DEPTH];
  logic [15:0] wcnt_ff;
  logic        pend_ff;
  logic [7:0]  pa_ff, pd_ff;
  wire  [15:0] lat = wr_thr_i ? 16'(THR_LAT) : 16'(REG_LAT);
  wire         commit = pend_ff && (wcnt_ff == 16'h0001);
  // [RULE6] short latency, [RULE7] threshold latency
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pend_ff <= 1'b0;
      wcnt_ff <= 16'h0000;
      pa_ff   <= 8'h00;
      pd_ff   <= 8'h00;
    end else if (wr_i && done_o && wr_addr_i < pucd_pkg::VOL_LAST) begin
      pend_ff <= 1'b1;
      wcnt_ff <= lat;
      pa_ff   <= wr_addr_i;
      pd_ff   <= wr_data_i;
    end else if (pend_ff) begin
      wcnt_ff <= wcnt_ff - 16'h0001;
      if (commit) pend_ff <= 1'b0;
    end
  end
  // [RULE10] [RULE11] nv location n lands in latch n; [RULE8] nv edits only on load
  always_ff @(posedge clk_i) begin
    // the copy has priority; a host commit that meets it is dropped, which
    // is the same as the reload overwriting it one cycle later
    if (rd_v_ff) vol_ff[wi_ff] <= nv_in_d_ff ? nv_rdata_i : pucd_pkg::CFG_RESET_VAL;
    else if (commit && !loading) vol_ff[pa_ff[5:0]] <= pd_ff;
  end
  wire [7:0] rd_sel = (cfg_addr_i <= pucd_pkg::VOL_LAST && done_o)
                      ? vol_ff[cfg_addr_i[5:0]] : pucd_pkg::CFG_RESET_VAL;

  ////////////////////////////////////////////////////////////////////////
  // outputs, all registered
  // [RULE1] assert low, [RULE4] follow conditions, [RULE5] NACK until done
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      outs_n_o    <= '0;
      done_o      <= 1'b0;
      host_nack_o <= 1'b0;
      cfg_data_o  <= 8'h00;
      cfg_busy_o  <= 1'b0;
    end else begin
      outs_n_o    <= lk_ok ? ~out_cond_i : '0;
      done_o      <= (nxt_st == pucd_pkg::ST_RUN);
      host_nack_o <= host_req_i && !(done_o && nxt_st == pucd_pkg::ST_RUN);
      cfg_data_o  <= rd_sel;
      cfg_busy_o  <= (wr_i && done_o && wr_addr_i < pucd_pkg::VOL_LAST) || (pend_ff && !commit);
    end
  end

  // load time bound checker
  logic [16:0] ld_cnt_ff;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) ld_cnt_ff <= 17'h0;
    else ld_cnt_ff <= loading ? ld_cnt_ff + 17'h1 : 17'h0;
  end
  // [RULE3] copy bounded
  a_load_time_bound: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ld_cnt_ff <= 17'(pucd_pkg::LOAD_MAX_CYC)) else $error("load exceeds limit"); // RULE3
  // [RULE5] nack before done
  a_nack_before_done: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (host_req_i && !done_o) |=> host_nack_o) else $error("no nack while loading"); // RULE5
  // [RULE1] outputs low before lockout
  a_outs_low_early: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !lk_ok |=> outs_n_o == '0) else $error("output released early"); // RULE1
  // [RULE4] outputs follow condition
  a_outs_follow: assert property (@(posedge clk_i) disable iff (!resetn_i)
    lk_ok |=> outs_n_o == ~$past(out_cond_i)) else $error("output not conditional"); // RULE4
  // [RULE2] load starts
  a_load_start: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (st_ff == pucd_pkg::ST_HOLD && lk_ok && por_ok) |=> loading)
    else $error("load not started"); // RULE2
  // [RULE11] done follows load
  a_done_after: assert property (@(posedge clk_i) disable iff (!resetn_i)
    $rose(done_o) |-> $past(loading)) else $error("done without load"); // RULE11
  // [RULE6] short write latency
  a_reg_latency: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (wr_i && done_o && !wr_thr_i && wr_addr_i < pucd_pkg::VOL_LAST && !reboot_i && lk_ok)
    |-> ##[1:101] !pend_ff) else $error("register write late"); // RULE6
  // [RULE9] pointer in image range
  a_nv_range: assert property (@(posedge clk_i) disable iff (!resetn_i)
    nv_addr_o >= pucd_pkg::NV_FIRST && nv_addr_o <= pucd_pkg::NV_LAST)
    else $error("nv pointer out of range"); // RULE9
  // [RULE11] pointer walks one step
  a_nv_walk: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE11
    (loading && nxt_st == pucd_pkg::ST_LOAD && !last_rd) |=> idx_ff == $past(idx_ff) + 6'h01)
    else $error("nv pointer skipped an entry");
  // [RULE5] nack lifted once running
  a_nack_released: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE5
    (host_req_i && done_o && st_ff == pucd_pkg::ST_RUN && !reboot_i && lk_ok && por_ok)
    |=> !host_nack_o) else $error("nack after load");
  // [RULE5] no write taken while loading
  // a host write that slips in before the copy would be overwritten anyway,
  // but refusing it keeps the busy flag honest for the host
  a_no_early_write: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE5
    (wr_i && !done_o && !pend_ff) |=> !pend_ff) else $error("write taken before done");
  // [RULE11] done low during load
  a_done_low_load: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE11
    loading |-> !done_o) else $error("done while loading");
endmodule : pucd_loader

// *** tb/pucd_nv_model.sv ***
module pucd_nv_model (
  input  wire logic       clk_i,   // system clock
  input  wire logic [7:0] addr_i,  // loader read pointer
  input  wire logic [7:0] salt_i,  // image variant, bench edits memory
  output logic      [7:0] rdata_o  // data one cycle after pointer
);
  timeunit 1ns;
  timeprecision 1ns;
  initial rdata_o = 8'h5a;
  // image only 80h..9fh
  // outside the image the bus toggles so a stray read never looks valid
  always @(posedge clk_i) begin
    if (addr_i >= 8'h80 && addr_i <= 8'h9f) rdata_o <= addr_i ^ salt_i;
    else rdata_o <= ~rdata_o;
  end
endmodule : pucd_nv_model

// *** tb/power_up_config_download_tb.sv ***
module power_up_config_download_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk_i = 1'b0, resetn_i = 1'b0, por_level_i = 1'b1, lockout_ok_i = 1'b0;
  logic       reboot_i = 1'b0, wr_i = 1'b0, wr_thr_i = 1'b0, host_req_i = 1'b0;
  logic [7:0] wr_addr_i = 8'h00, wr_data_i = 8'h00, cfg_addr_i = 8'h00;
  logic [7:0] salt = 8'h3c, live = 8'h3c, nv_rdata_i, nv_addr_o, cfg_data_o;
  logic       cfg_busy_o, host_nack_o, done_o;
  logic [2:0] out_cond_i = 3'h5, outs_n_o;
  int         failures = 0, samples_checked = 0, cycles = 0;
  //////////////////////////////////////////////////
  pucd_loader #(.REG_LAT(4), .THR_LAT(10), .OUT_N(3)) DUT (
    .clk_i(clk_i), .resetn_i(resetn_i), .por_level_i(por_level_i),
    .lockout_ok_i(lockout_ok_i), .reboot_i(reboot_i), .nv_rdata_i(nv_rdata_i),
    .nv_addr_o(nv_addr_o), .wr_i(wr_i), .wr_addr_i(wr_addr_i), .wr_data_i(wr_data_i),
    .wr_thr_i(wr_thr_i), .cfg_addr_i(cfg_addr_i), .cfg_data_o(cfg_data_o),
    .cfg_busy_o(cfg_busy_o), .host_req_i(host_req_i), .host_nack_o(host_nack_o),
    .done_o(done_o), .out_cond_i(out_cond_i), .outs_n_o(outs_n_o));
  pucd_nv_model nv (.clk_i(clk_i), .addr_i(nv_addr_o), .salt_i(salt), .rdata_o(nv_rdata_i));
  // clock and hang guard; a load should finish in well under this
  initial forever #25 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      conclude();
    end
  end
  //////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // latch n holds image byte 80h+n, upper latches load zero
  function automatic logic [7:0] exp_cfg(input logic [7:0] a);
    return (a < 8'h20) ? ((a | 8'h80) ^ live) : 8'h00;
  endfunction : exp_cfg
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    cfg_addr_i = a;
    repeat (2) @(negedge clk_i);
    chk("cfg_data_o", exp, cfg_data_o);
  endtask : rdchk
  task automatic check_image();
    logic [7:0] pts[6] = '{8'h00, 8'h10, 8'h1f, 8'h20, 8'h2f, 8'h30};
    foreach (pts[i]) rdchk(pts[i], exp_cfg(pts[i]));
  endtask : check_image
  task automatic wait_load();
    int n = 0;
    while (done_o !== 1'b1 && n < 50005) begin
      @(negedge clk_i);
      n++;
    end
    chk("load_in_time", 8'h01, {7'h0, n < pucd_pkg::LOAD_MAX_CYC});
  endtask : wait_load
  //////////////////////////////////////////////////
  task automatic power_on();
    host_req_i = 1'b1;
    repeat (5) @(negedge clk_i);
    chk("outs_n_o", 8'h00, {5'h0, outs_n_o});
    chk("host_nack_o", 8'h01, {7'h0, host_nack_o});
    chk("nv_addr_o", 8'h80, nv_addr_o);
    lockout_ok_i = 1'b1;
    repeat (3) @(negedge clk_i);
    chk("host_nack_o", 8'h01, {7'h0, host_nack_o});
    wait_load();
    repeat (2) @(negedge clk_i);
    chk("host_nack_o", 8'h00, {7'h0, host_nack_o});
    chk("outs_n_o", {5'h0, ~out_cond_i}, {5'h0, outs_n_o});
    chk("nv_addr_o", 8'h9f, nv_addr_o);
    check_image();
  endtask : power_on
  // old value must still show one cycle after the write is taken
  task automatic write_cfg(input logic [7:0] a, d, input logic thr, input int lat);
    int n = 0;
    cfg_addr_i = a;
    wr_addr_i = a;
    wr_data_i = d;
    wr_thr_i = thr;
    wr_i = 1'b1;
    @(negedge clk_i);
    wr_i = 1'b0;
    chk("cfg_old", exp_cfg(a), cfg_data_o);
    while (cfg_busy_o === 1'b1 && n < 100) begin
      @(negedge clk_i);
      n++;
    end
    chk("write_lat", 8'h01, {7'h0, n >= lat - 2 && n <= lat + 2});
    rdchk(a, d);
  endtask : write_cfg
  task automatic nv_edit();
    salt = 8'hc3;
    repeat (4) @(negedge clk_i);
    check_image();
    reboot_i = 1'b1;
    @(negedge clk_i);
    reboot_i = 1'b0;
    live = salt;
    repeat (2) @(negedge clk_i);
    wait_load();
    check_image();
  endtask : nv_edit
  task automatic conclude();
    $display("failures %0d samples_checked %0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  initial begin
    repeat (3) @(negedge clk_i);
    resetn_i = 1'b1;
    power_on();
    write_cfg(8'h05, 8'ha7, 1'b0, 4);
    write_cfg(8'h0c, 8'h19, 1'b1, 10);
    nv_edit();
    conclude();
  end
endmodule : power_up_config_download_tb
